// File: src/hws_pkg.sv
// constants, enumerations and carrier types for the haptic waveform sequencer
// assumes one 25 MHz clock; the serial host port is decoded outside into byte writes
package hws_pkg;

    // register byte offsets
    localparam logic [7:0] SLOT_BASE_ADDR = 8'h04;
    localparam logic [7:0] SLOT_LAST_ADDR = 8'h0B;
    localparam logic [7:0] TRIGGER_ADDR = 8'h0C;
    localparam logic [7:0] OVERDRIVE_ADDR = 8'h0D;

    // field positions and reset values
    localparam int SLOT_WAIT_BIT = 7;
    localparam int TRIGGER_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_SLOTS = 8;
    localparam logic [2:0] LAST_SLOT = 3'h7;
    localparam logic [2:0] LIB_EMPTY = 3'h0;
    localparam int NUM_SEGS = 3;
    localparam logic [1:0] LAST_SEG = 2'h2;

    // timing: one tick is the 5 ms offset grain, a wait count is 10 ms
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 5;
    localparam int WAIT_MS = 10;
    localparam int TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS;
    localparam int WAIT_TICKS = WAIT_MS / TICK_MS;

    // operating modes of the trigger
    typedef enum logic [2:0] {
        HWS_MODE_INT_TRIG,
        HWS_MODE_EXT_EDGE,
        HWS_MODE_EXT_LEVEL,
        HWS_MODE_PWM_ANALOG,
        HWS_MODE_AUDIO,
        HWS_MODE_REALTIME,
        HWS_MODE_DIAG,
        HWS_MODE_CALIB
    } hws_mode_t;

    // one byte write from the host port
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hws_reg_req_t;

    // one segment of a library waveform: signed level and length in ticks
    typedef struct packed {
        logic signed [7:0] amp;
        logic [7:0] ticks;
    } hws_seg_t;

endpackage : hws_pkg

// File: src/hws_sequencer.sv
// waveform playback sequencer: eight slots, trigger bit, overdrive offset
// assumes a host port already turned into single-cycle byte writes, synchronous
// trigger pin, and calibration/diagnostic engines that report their end
`timescale 1ns/10ps

// Notes on behaviour
// - slot top bit one: low seven bits are a wait, engine idles
// - wait length is the seven-bit value times ten milliseconds
// - slot top bit zero: low seven bits index the waveform
// - index selects one waveform of a read-only library
// - setting the trigger starts playback at the first slot
// - after a waveform ends, go to the next slot if non-zero
// - playback stops at first zero slot or after eight slots
// - trigger starts whatever process the operating mode selects; PWM, audio and realtime modes start nothing here
// - trigger reads one during playback, cleared by device at end
// - host writing zero to the trigger aborts the sequence
// - external trigger modes let the pin set the trigger; only level mode lets the pin clear it
// - calibration and diagnostic modes launch those routines instead
// - highest-level segment of a waveform is its overdrive portion
// - overdrive offset used only open-loop, ignored closed-loop
// - offset is signed, five milliseconds per count
// - waveforms come from the library chosen by the selection field
module hws_sequencer #(
    parameter int TICK_CYCLES = hws_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic srst,
    input wire hws_pkg::hws_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire hws_pkg::hws_mode_t mode,
    input wire logic [2:0] library_sel,
    input wire logic closed_loop,
    input wire logic trig_pin,
    input wire logic routine_done,
    output logic signed [7:0] drive_level,
    output logic playing,
    output logic calib_start,
    output logic diag_start
);
    import hws_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // library contents and helpers

    // synthetic read-only library: lead-in level, overdrive (peak), brake per waveform
    function automatic hws_seg_t lib_seg(input logic [2:0] lib, input logic [6:0] idx,
                                          input logic [1:0] seg);
        hws_seg_t s;
        s.amp = 8'sh00;
        s.ticks = 8'h00;
        if (lib != LIB_EMPTY) begin
            case (seg)
                2'h0: begin
                    s.amp = 8'sh40 + $signed({4'h0, idx[3:0]});
                    s.ticks = 8'h04 + {5'h00, idx[2:0]};
                end
                2'h1: begin
                    s.amp = 8'sh7F;
                    s.ticks = 8'h02 + {5'h00, lib};
                end
                default: begin
                    s.amp = -8'sh60;
                    s.ticks = 8'h02;
                end
            endcase
        end
        return s;
    endfunction

    // position of the highest level among the segments
    // ties keep the earlier segment, so an empty library picks segment zero
    function automatic logic [1:0] peak_seg(input logic [2:0] lib, input logic [6:0] idx);
        logic [1:0] best;
        hws_seg_t top;
        hws_seg_t cand;
        best = 2'h0;
        top = lib_seg(lib, idx, 2'h0);
        for (int k = 1; k < NUM_SEGS; k++) begin
            cand = lib_seg(lib, idx, k[1:0]);
            if (cand.amp > top.amp) begin
                top = cand;
                best = k[1:0];
            end
        end
        return best;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLOT,
        ST_SEG_LOAD,
        ST_RUN,
        ST_ROUTINE
    } hws_state_t;

    logic [7:0] slot_r [NUM_SLOTS];
    logic go_r, go_nxt;
    logic [7:0] overdrive_offset_r;
    logic trig_pin_d_r;
    hws_state_t state_r, state_nxt;
    logic [2:0] slot_idx_r, slot_idx_nxt;
    logic [1:0] seg_idx_r, seg_idx_nxt;
    logic [2:0] lib_r, lib_nxt;
    logic [6:0] wave_r, wave_nxt;
    logic [9:0] remain_r, remain_nxt;
    logic [31:0] tick_cnt_r;
    logic signed [7:0] drive_level_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // host port decode

    wire slot_hit = reg_req.addr >= SLOT_BASE_ADDR && reg_req.addr <= SLOT_LAST_ADDR;
    wire [2:0] slot_wsel = 3'(reg_req.addr - SLOT_BASE_ADDR);
    wire go_wr = reg_req.wr && reg_req.addr == TRIGGER_ADDR;
    wire go_wr_set = go_wr && reg_req.wdata[TRIGGER_BIT];
    wire go_wr_clr = go_wr && !reg_req.wdata[TRIGGER_BIT];
    wire od_wr = reg_req.wr && reg_req.addr == OVERDRIVE_ADDR;

    // reserved trigger bits and unmapped addresses read zero
    assign reg_rdata = slot_hit ? slot_r[slot_wsel] :
                       reg_req.addr == TRIGGER_ADDR ? {7'h00, go_r} :
                       reg_req.addr == OVERDRIVE_ADDR ? overdrive_offset_r : REG_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // trigger sources

    wire ext_edge = mode == HWS_MODE_EXT_EDGE;
    wire ext_level = mode == HWS_MODE_EXT_LEVEL;
    wire pin_rise = trig_pin && !trig_pin_d_r;
    wire pin_set = (ext_edge && pin_rise) || (ext_level && trig_pin);
    wire pin_clr = ext_level && !trig_pin;
    wire host_or_pin_set = go_wr_set || pin_set;
    wire abort = go_r && (go_wr_clr || pin_clr);

    wire tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
    wire seq_done_hw;

    // device clear at the end loses to a set in the same cycle
    always_comb begin
        go_nxt = go_r;
        if (seq_done_hw) begin
            go_nxt = 1'b0;
        end
        if (go_wr_clr || pin_clr) begin
            go_nxt = 1'b0;
        end
        if (host_or_pin_set) begin
            go_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // playback engine

    wire [7:0] cur_slot = slot_r[slot_idx_r];
    wire slot_is_wait = cur_slot[SLOT_WAIT_BIT];
    hws_seg_t cur_seg;
    assign cur_seg = lib_seg(lib_r, wave_r, seg_idx_r);
    wire is_overdrive = seg_idx_r == peak_seg(lib_r, wave_r);
    // offset in 5 ms ticks, signed, only when running open loop
    wire signed [9:0] od_adj = closed_loop ? 10'sh000 :
                               10'($signed(overdrive_offset_r));
    wire signed [9:0] seg_len = $signed({2'b00, cur_seg.ticks}) + (is_overdrive ? od_adj : 10'sh000);
    wire [9:0] seg_len_clip = seg_len[9] ? 10'h000 : seg_len;
    wire start_req = go_r && state_r == ST_IDLE;
    wire routine_mode = mode == HWS_MODE_CALIB || mode == HWS_MODE_DIAG;

    // advance to the following slot or finish after the last one
    wire last_slot = slot_idx_r == LAST_SLOT;
    assign seq_done_hw = (state_r == ST_SLOT && cur_slot == REG_RESET) ||
                         (state_r == ST_ROUTINE && routine_done) ||
                         (state_r == ST_RUN && remain_r == 10'h000 && last_slot &&
                          (slot_is_wait || seg_idx_r == LAST_SEG)) ||
                         (state_r == ST_SEG_LOAD && seg_len_clip == 10'h000 &&
                          seg_idx_r == LAST_SEG && last_slot);

    always_comb begin
        state_nxt = state_r;
        slot_idx_nxt = slot_idx_r;
        seg_idx_nxt = seg_idx_r;
        lib_nxt = lib_r;
        wave_nxt = wave_r;
        remain_nxt = remain_r;
        drive_level_nxt = 8'sh00;
        case (state_r)
            ST_IDLE: begin
                if (start_req) begin
                    if (routine_mode) begin
                        state_nxt = ST_ROUTINE;
                    end else if (mode == HWS_MODE_INT_TRIG || ext_edge || ext_level) begin
                        slot_idx_nxt = 3'h0;
                        lib_nxt = library_sel;
                        state_nxt = ST_SLOT;
                    end
                end
            end
            ST_SLOT: begin
                if (cur_slot == REG_RESET) begin
                    state_nxt = ST_IDLE;
                end else if (slot_is_wait) begin
                    remain_nxt = 10'(cur_slot[6:0]) * 10'(WAIT_TICKS);
                    state_nxt = ST_RUN;
                end else begin
                    wave_nxt = cur_slot[6:0];
                    seg_idx_nxt = 2'h0;
                    state_nxt = ST_SEG_LOAD;
                end
            end
            ST_SEG_LOAD: begin
                remain_nxt = seg_len_clip;
                if (seg_len_clip != 10'h000) begin
                    state_nxt = ST_RUN;
                end else if (seg_idx_r != LAST_SEG) begin
                    seg_idx_nxt = seg_idx_r + 2'h1;
                end else if (last_slot) begin
                    state_nxt = ST_IDLE;
                end else begin
                    slot_idx_nxt = slot_idx_r + 3'h1;
                    state_nxt = ST_SLOT;
                end
            end
            ST_RUN: begin
                drive_level_nxt = slot_is_wait ? 8'sh00 : cur_seg.amp;
                if (remain_r == 10'h000) begin
                    drive_level_nxt = 8'sh00;
                    if (!slot_is_wait && seg_idx_r != LAST_SEG) begin
                        seg_idx_nxt = seg_idx_r + 2'h1;
                        state_nxt = ST_SEG_LOAD;
                    end else if (last_slot) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        slot_idx_nxt = slot_idx_r + 3'h1;
                        state_nxt = ST_SLOT;
                    end
                end else if (tick) begin
                    remain_nxt = remain_r - 10'h001;
                end
            end
            ST_ROUTINE: begin
                if (routine_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (abort) begin
            state_nxt = ST_IDLE;
            drive_level_nxt = 8'sh00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flops

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_r[i] <= REG_RESET;
            end
        end else if (reg_req.wr && slot_hit) begin
            slot_r[slot_wsel] <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overdrive_offset_r <= REG_RESET;
        end else if (od_wr) begin
            overdrive_offset_r <= reg_req.wdata;
        end
    end

    // tick grid restarts with every new segment or wait
    always_ff @(posedge clk) begin
        if (srst || state_r != ST_RUN || tick) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // trigger bit and pin history; pin history resets low to match the idle pin
    always_ff @(posedge clk) begin
        if (srst) begin
            go_r <= 1'b0;
            trig_pin_d_r <= 1'b0;
        end else begin
            go_r <= go_nxt;
            trig_pin_d_r <= trig_pin;
        end
    end

    // sequencer position
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            slot_idx_r <= 3'h0;
            seg_idx_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            slot_idx_r <= slot_idx_nxt;
            seg_idx_r <= seg_idx_nxt;
        end
    end

    // latched library, waveform and remaining ticks of the current step
    always_ff @(posedge clk) begin
        if (srst) begin
            lib_r <= LIB_EMPTY;
            wave_r <= 7'h00;
            remain_r <= 10'h000;
        end else begin
            lib_r <= lib_nxt;
            wave_r <= wave_nxt;
            remain_r <= remain_nxt;
        end
    end

    // registered outputs to the load and the routine engines
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_level <= 8'sh00;
            calib_start <= 1'b0;
            diag_start <= 1'b0;
        end else begin
            drive_level <= drive_level_nxt;
            calib_start <= start_req && !abort && mode == HWS_MODE_CALIB;
            diag_start <= start_req && !abort && mode == HWS_MODE_DIAG;
        end
    end

    assign playing = state_r != ST_IDLE && state_r != ST_ROUTINE;

endmodule // hws_sequencer

// File: tb/hws_host_model.sv
// host model: single byte writes and combinational reads on the register port
// assumes the bench calls its tasks; all changes land on the falling edge
`timescale 1ns/10ps
module hws_host_model (
    input wire logic clk,
    output hws_pkg::hws_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import hws_pkg::*;
    initial reg_req = '0;
    // data is scrambled once the strobe drops so stale bytes cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr = 1'b0;
        reg_req.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req.addr = a;
        #1 d = reg_rdata;
    endtask
endmodule // hws_host_model

// File: tb/hws_sequencer_properties.sv
// port checker for the waveform sequencer
// assumes mode is only changed while the trigger bit is low
`timescale 1ns/10ps
module hws_seq_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire hws_pkg::hws_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire hws_pkg::hws_mode_t mode,
    input wire logic [2:0] library_sel,
    input wire logic closed_loop,
    input wire logic trig_pin,
    input wire logic routine_done,
    input wire logic signed [7:0] drive_level,
    input wire logic playing,
    input wire logic calib_start,
    input wire logic diag_start
);
    import hws_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire go_wr = reg_req.wr && reg_req.addr == TRIGGER_ADDR;
    ////////////////////////////////////////////////////////////////////////////////
    chk_go_held: assert property (playing && reg_req.addr == TRIGGER_ADDR |-> reg_rdata == 8'h01)
        else $error("trigger bit low during playback");
    chk_start_play: assert property (go_wr && reg_req.wdata[0] && mode == HWS_MODE_INT_TRIG
        && reg_rdata == 8'h00 |=> ##1 playing) else $error("playback did not start");
    chk_abort_play: assert property (go_wr && !reg_req.wdata[0] && playing |=> ##[0:1] !playing)
        else $error("abort did not stop playback");
    chk_mode_noplay: assert property (mode inside {HWS_MODE_PWM_ANALOG, HWS_MODE_AUDIO,
        HWS_MODE_REALTIME, HWS_MODE_DIAG, HWS_MODE_CALIB} |-> !playing) else $error("play in bad mode");
    chk_calib_pulse: assert property (calib_start |=> !calib_start)
        else $error("calibration start longer than one cycle");
    chk_calib_mode: assert property (calib_start |-> $past(mode) == HWS_MODE_CALIB)
        else $error("calibration start in wrong mode");
    chk_diag_mode: assert property (diag_start |-> $past(mode) == HWS_MODE_DIAG && !playing)
        else $error("diagnostic start in wrong mode");
    chk_idle_drive: assert property (!playing && !$past(playing) |-> drive_level == 8'sh00)
        else $error("drive level while idle");
    chk_level_clear: assert property (mode == HWS_MODE_EXT_LEVEL && !trig_pin |-> ##2 !playing)
        else $error("low trigger pin did not stop playback");
    cover property (calib_start);
    cover property (diag_start);
    cover property ($rose(playing));
    cover property (drive_level == 8'sh7F);
endmodule // hws_seq_props
bind hws_sequencer hws_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk, .srst, .reg_req,
    .reg_rdata, .mode, .library_sel, .closed_loop, .trig_pin, .routine_done, .drive_level,
    .playing, .calib_start, .diag_start);

// File: tb/hws_sequencer_tb.sv
// self-checking bench for the waveform sequencer
// assumes a shortened tick of 4 clocks; expectations use differences of run lengths
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module hws_sequencer_tb;
    import hws_pkg::*;
    localparam int TC = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    hws_reg_req_t reg_req;
    logic [7:0] reg_rdata, rv;
    hws_mode_t mode = HWS_MODE_INT_TRIG;
    logic [2:0] library_sel = 3'h1;
    logic closed_loop = 1'b0, trig_pin = 1'b0, routine_done = 1'b0;
    logic signed [7:0] drive_level;
    logic playing, calib_start, diag_start;
    int errors = 0, check_count = 0, cycles = 0, n_play, n_od, n_burst, base;
    hws_sequencer #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .srst(srst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .mode(mode), .library_sel(library_sel), .closed_loop(closed_loop),
        .trig_pin(trig_pin), .routine_done(routine_done), .drive_level(drive_level),
        .playing(playing), .calib_start(calib_start), .diag_start(diag_start));
    hws_host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // slot 0 is the leftmost byte; counts playing, overdrive cycles and bursts
    task automatic play(input logic [63:0] sl);
        int n;
        logic prev;
        for (int i = 0; i < 8; i++) host.wr(SLOT_BASE_ADDR + 8'(i), sl[63-8*i -: 8]);
        host.wr(TRIGGER_ADDR, 8'h01);
        n_play = 0; n_od = 0; n_burst = 0; n = 0; prev = 1'b0;
        while (reg_rdata[TRIGGER_BIT] === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
            n_play += int'(playing);
            if (drive_level === 8'sh7F && !prev) n_burst++;
            prev = (drive_level === 8'sh7F);
            n_od += int'(prev);
        end
        `CHK(reg_rdata[TRIGGER_BIT], 1'b0)
    endtask
    task automatic t_regs();
        for (int a = 4; a < 14; a++) begin
            host.rd(8'(a), rv);
            `CHK(rv, REG_RESET)
        end
        for (int a = 4; a < 12; a++) host.wr(8'(a), 8'hA0 + 8'(a));
        host.wr(OVERDRIVE_ADDR, 8'h5A);
        host.wr(8'h20, 8'h55);
        for (int a = 4; a < 12; a++) begin
            host.rd(8'(a), rv);
            `CHK(rv, 8'hA0 + 8'(a))
        end
        host.rd(OVERDRIVE_ADDR, rv);
        `CHK(rv, 8'h5A)
        host.rd(8'h20, rv);
        `CHK(rv, 8'h00)
        host.wr(OVERDRIVE_ADDR, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_seq();
        play(64'h0102030405060708);
        `CHK(n_burst, 8)
        play(64'h0102000300000000);
        `CHK(n_burst, 2)
        play(64'h0000000000000000);
        `CHK(n_burst, 0)
        $display("test sequence done");
    endtask
    task automatic t_wait();
        play(64'h0183010000000000);
        base = n_play;
        `CHK(n_burst, 2)
        play(64'h0180010000000000);
        `CHK(n_burst, 2)
        `CHK(base - n_play, 3 * WAIT_TICKS * TC)
        $display("test wait done");
    endtask
    task automatic t_odt();
        play(64'h0100000000000000);
        base = n_od;
        host.wr(OVERDRIVE_ADDR, 8'h02);
        play(64'h0100000000000000);
        `CHK(n_od - base, 2 * TC)
        host.wr(OVERDRIVE_ADDR, 8'hFF);
        play(64'h0100000000000000);
        `CHK(n_od - base, -TC)
        closed_loop = 1'b1;
        play(64'h0100000000000000);
        `CHK(n_od - base, 0)
        closed_loop = 1'b0;
        library_sel = 3'h2;
        host.wr(OVERDRIVE_ADDR, 8'h00);
        play(64'h0100000000000000);
        `CHK(n_od - base, TC)
        library_sel = LIB_EMPTY;
        play(64'h0100000000000000);
        `CHK(n_burst, 0)
        library_sel = 3'h1;
        $display("test overdrive done");
    endtask
    task automatic t_abort();
        host.wr(SLOT_BASE_ADDR, 8'h08);
        host.wr(TRIGGER_ADDR, 8'h01);
        repeat (8) @(negedge clk);
        `CHK(playing, 1'b1)
        host.wr(TRIGGER_ADDR, 8'h00);
        repeat (2) @(negedge clk);
        `CHK(playing, 1'b0)
        `CHK(drive_level, 8'sh00)
        $display("test abort done");
    endtask
    task automatic t_modes();
        hws_mode_t ml[2] = '{HWS_MODE_DIAG, HWS_MODE_CALIB};
        logic sc, sd;
        foreach (ml[k]) begin
            mode = ml[k];
            sc = 1'b0; sd = 1'b0;
            host.wr(TRIGGER_ADDR, 8'h01);
            repeat (4) @(negedge clk) begin
                sc |= calib_start;
                sd |= diag_start;
            end
            `CHK(sd, ml[k] == HWS_MODE_DIAG)
            `CHK(sc, ml[k] == HWS_MODE_CALIB)
            `CHK(reg_rdata[TRIGGER_BIT], 1'b1)
            routine_done = 1'b1;
            @(negedge clk) routine_done = 1'b0;
            repeat (2) @(negedge clk);
            `CHK(reg_rdata[TRIGGER_BIT], 1'b0)
        end
        mode = HWS_MODE_PWM_ANALOG;
        host.wr(TRIGGER_ADDR, 8'h01);
        repeat (4) @(negedge clk);
        `CHK(playing, 1'b0)
        host.wr(TRIGGER_ADDR, 8'h00);
        mode = HWS_MODE_EXT_EDGE;
        @(negedge clk) trig_pin = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(reg_rdata[TRIGGER_BIT], 1'b1)
        trig_pin = 1'b0;
        for (int n = 0; n < 600 && reg_rdata[TRIGGER_BIT] !== 1'b0; n++) @(negedge clk);
        `CHK(reg_rdata[TRIGGER_BIT], 1'b0)
        mode = HWS_MODE_EXT_LEVEL;
        @(negedge clk) trig_pin = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(playing, 1'b1)
        trig_pin = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(reg_rdata[TRIGGER_BIT], 1'b0)
        mode = HWS_MODE_INT_TRIG;
        $display("test modes done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_regs();
        t_seq();
        t_wait();
        t_odt();
        t_abort();
        t_modes();
        stop_test();
    end
endmodule // hws_sequencer_tb
